// ---- alu_core.sv ----
// Eight-bit arithmetic and Boolean unit with accumulator and auxiliary register
`default_nettype none
module alu_core #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [7:0] operand,
  input wire logic [2:0] bit_sel,
  output logic op_ready,
  output logic jump_taken,
  output logic bit_out,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [15:0] external_data_space_addr,
  output logic radio_sel,
  output logic [4:0] bank_base
);
  typedef struct packed {
    alu_pkg::alu_state_t state;
    logic [7:0] acc;
    logic [7:0] aux;
    logic [3:0] cnt;
    logic [7:0] rem;
    logic jmp;
    logic bo;
    logic [7:0] rdata;
  } core_state_t;
  core_state_t st_r, st_nxt;
  sfr_if sfr();
  logic flag_we;
  logic [7:0] flag_mask, flag_val, psw;
  logic parity;

  assign sfr.wr = sfr_wr;
  assign sfr.addr = sfr_addr;
  assign sfr.wdata = sfr_wdata;
  assign psw = sfr.psw;
  assign parity = ^st_r.acc;

  psw_unit u_psw (
    .mclk(mclk),
    .rstn(rstn),
    .sfr(sfr),
    .flag_we(flag_we),
    .flag_mask(flag_mask),
    .flag_val(flag_val),
    .parity(parity),
    .bank_base(bank_base)
  );

  // Decoder for radio register window in external data space
  assign radio_sel = external_data_space_addr >= alu_pkg::RADIO_LO && external_data_space_addr <= alu_pkg::RADIO_HI;
  assign sfr_hit = sfr_addr == alu_pkg::ACC_ADDR || sfr_addr == alu_pkg::AUX_ADDR ||
    sfr_addr == alu_pkg::PSW_ADDR;
  assign op_ready = st_r.state == alu_pkg::ST_IDLE;
  assign jump_taken = st_r.jmp;
  assign bit_out = st_r.bo;
  assign sfr_rdata = st_r.rdata;

  // Operation datapath; divide runs bit-serially to save a wide divider
  always_comb
  begin
    logic cy, ov, b;
    logic [8:0] s9;
    logic [4:0] s5;
    logic [15:0] prod;
    logic [8:0] trial;
    logic [7:0] da;
    logic [7:0] bm;
    cy = psw[alu_pkg::CY_BIT];
    ov = 1'b0;
    b = 1'b0;
    s9 = '0;
    s5 = '0;
    prod = '0;
    trial = '0;
    da = '0;
    bm = 8'h01 << bit_sel;
    st_nxt = st_r;
    st_nxt.jmp = 1'b0;
    flag_we = 1'b0;
    flag_mask = 8'h00;
    flag_val = 8'h00;
    // Register reads sample current contents
    if (sfr_rd)
    begin
      case (sfr_addr)
        alu_pkg::ACC_ADDR: st_nxt.rdata = st_r.acc;
        alu_pkg::AUX_ADDR: st_nxt.rdata = st_r.aux;
        alu_pkg::PSW_ADDR: st_nxt.rdata = psw;
        default: st_nxt.rdata = alu_pkg::RESET_BYTE;
      endcase
    end
    if (sfr_wr && sfr_addr == alu_pkg::ACC_ADDR)
      st_nxt.acc = sfr_wdata;
    if (sfr_wr && sfr_addr == alu_pkg::AUX_ADDR)
      st_nxt.aux = sfr_wdata;
    case (st_r.state)
      alu_pkg::ST_IDLE:
      begin
        if (op_valid)
        begin
          case (alu_pkg::alu_op_t'(op_code))
            alu_pkg::OP_ADD, alu_pkg::OP_ADDC, alu_pkg::OP_SUBB, alu_pkg::OP_CMP:
            begin
              b = (op_code == alu_pkg::OP_ADD) ? 1'b0 : cy;
              if (op_code == alu_pkg::OP_ADD || op_code == alu_pkg::OP_ADDC)
              begin
                s9 = {1'b0, st_r.acc} + {1'b0, operand} + {8'h00, b};
                s5 = {1'b0, st_r.acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, b};
                ov = (st_r.acc[7] == operand[7]) && (s9[7] != st_r.acc[7]);
              end
              else
              begin
                s9 = {1'b0, st_r.acc} - {1'b0, operand} - {8'h00, b};
                s5 = {1'b0, st_r.acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, b};
                ov = (st_r.acc[7] != operand[7]) && (s9[7] != st_r.acc[7]);
              end
              // Compare only sets carry, leaving the accumulator intact
              if (op_code != alu_pkg::OP_CMP)
              begin
                st_nxt.acc = s9[7:0];
                flag_mask = 8'hC4;
              end
              else
                flag_mask = 8'h80;
              flag_we = 1'b1;
              flag_val = {s9[8], s5[4], 3'b000, ov, 2'b00};
            end
            alu_pkg::OP_INC: st_nxt.acc = st_r.acc + 8'h01;
            alu_pkg::OP_DEC: st_nxt.acc = st_r.acc - 8'h01;
            alu_pkg::OP_MUL:
            begin
              prod = st_r.acc * st_r.aux;
              st_nxt.acc = prod[7:0];
              st_nxt.aux = prod[15:8];
              flag_we = 1'b1;
              flag_mask = 8'h84;
              flag_val = {5'h00, prod[15:8] != 8'h00, 2'b00};
            end
            alu_pkg::OP_DIV:
            begin
              flag_we = 1'b1;
              flag_mask = 8'h84;
              flag_val = {5'h00, st_r.aux == 8'h00, 2'b00};
              if (st_r.aux != 8'h00)
              begin
                st_nxt.state = alu_pkg::ST_DIV;
                st_nxt.cnt = 4'h0;
                st_nxt.rem = 8'h00;
              end
            end
            alu_pkg::OP_DA:
            begin
              da = st_r.acc;
              s9 = {1'b0, da};
              if (da[3:0] > 4'h9 || psw[alu_pkg::AC_BIT])
                s9 = s9 + 9'h006;
              if (s9[8:4] > 5'h09 || cy)
                s9 = s9 + 9'h060;
              st_nxt.acc = s9[7:0];
              flag_we = 1'b1;
              flag_mask = 8'h80;
              flag_val = {s9[8] | cy, 7'h00};
            end
            alu_pkg::OP_AND: st_nxt.acc = st_r.acc & operand;
            alu_pkg::OP_OR: st_nxt.acc = st_r.acc | operand;
            alu_pkg::OP_XOR: st_nxt.acc = st_r.acc ^ operand;
            alu_pkg::OP_CPL: st_nxt.acc = ~st_r.acc;
            alu_pkg::OP_CLR: st_nxt.acc = alu_pkg::RESET_BYTE;
            alu_pkg::OP_RL: st_nxt.acc = {st_r.acc[6:0], st_r.acc[7]};
            alu_pkg::OP_RR: st_nxt.acc = {st_r.acc[0], st_r.acc[7:1]};
            alu_pkg::OP_RLC, alu_pkg::OP_RRC:
            begin
              if (op_code == alu_pkg::OP_RLC)
                {b, st_nxt.acc} = {st_r.acc, cy};
              else
                {st_nxt.acc, b} = {cy, st_r.acc};
              flag_we = 1'b1;
              flag_mask = 8'h80;
              flag_val = {b, 7'h00};
            end
            // Bit ops address the accumulator bits; bit test outputs result
            alu_pkg::OP_BSET: st_nxt.acc = st_r.acc | bm;
            alu_pkg::OP_BCLR: st_nxt.acc = st_r.acc & ~bm;
            alu_pkg::OP_BCPL: st_nxt.acc = st_r.acc ^ bm;
            alu_pkg::OP_BTST: st_nxt.jmp = ~st_r.acc[bit_sel];
            alu_pkg::OP_BTCLR:
            begin
              st_nxt.jmp = st_r.acc[bit_sel];
              st_nxt.acc = st_r.acc & ~bm;
            end
            alu_pkg::OP_BTOC:
            begin
              flag_we = 1'b1;
              flag_mask = 8'h80;
              flag_val = {st_r.acc[bit_sel], 7'h00};
            end
            alu_pkg::OP_CTOB:
            begin
              st_nxt.acc = cy ? (st_r.acc | bm) : (st_r.acc & ~bm);
              st_nxt.bo = cy;
            end
            default: st_nxt.acc = st_r.acc;
          endcase
        end
      end
      alu_pkg::ST_DIV:
      begin
        // Restoring division: quotient shifts into acc, remainder into aux
        trial = {st_r.rem, st_r.acc[7]} - {1'b0, st_r.aux};
        if (!trial[8])
        begin
          st_nxt.rem = trial[7:0];
          st_nxt.acc = {st_r.acc[6:0], 1'b1};
        end
        else
        begin
          st_nxt.rem = {st_r.rem[6:0], st_r.acc[7]};
          st_nxt.acc = {st_r.acc[6:0], 1'b0};
        end
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt == alu_pkg::DIV_LAST)
        begin
          st_nxt.aux = st_nxt.rem;
          st_nxt.state = alu_pkg::ST_IDLE;
        end
      end
      default: st_nxt.state = alu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  sequence div_start_s;
    op_ready && op_valid && op_code == alu_pkg::OP_DIV && st_r.aux != 8'h00;
  endsequence
  div_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
    div_start_s |=> !op_ready [*8] ##1 op_ready)
    else $error("divide length wrong");
  radio_decode_a: assert property (@(posedge mclk) disable iff (!rstn)
    radio_sel == (external_data_space_addr[15:8] == 8'h08))
    else $error("radio decode wrong");
  acc_read_a: assert property (@(posedge mclk) disable iff (!rstn)
    sfr_rd && sfr_addr == 8'hE0 |=> sfr_rdata == $past(st_r.acc))
    else $error("acc read wrong");
  mul_result_a: assert property (@(posedge mclk) disable iff (!rstn)
    op_ready && op_valid && op_code == alu_pkg::OP_MUL && !sfr_wr |=>
    {st_r.aux, st_r.acc} == $past(st_r.acc) * $past(st_r.aux))
    else $error("multiply result wrong");
  and_op_a: assert property (@(posedge mclk) disable iff (!rstn)
    op_ready && op_valid && op_code == alu_pkg::OP_AND && !sfr_wr |=>
    st_r.acc == ($past(st_r.acc) & $past(operand)))
    else $error("and result wrong");
  add_carry_a: assert property (@(posedge mclk) disable iff (!rstn)
    op_ready && op_valid && op_code == alu_pkg::OP_ADD |=>
    psw[7] == (({1'b0, $past(st_r.acc)} + {1'b0, $past(operand)}) > 9'h0FF))
    else $error("add carry wrong");
  jbc_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
    op_ready && op_valid && op_code == alu_pkg::OP_BTCLR && !sfr_wr |=>
    st_r.acc[$past(bit_sel)] == 1'b0 && jump_taken == $past(st_r.acc[bit_sel]))
    else $error("jump clear wrong");
  psw_layout_a: assert property (@(posedge mclk) disable iff (!rstn)
    bank_base == {psw[4:3], 3'b000})
    else $error("bank field misplaced");
endmodule : alu_core
`default_nettype wire

// ---- alu_pkg.sv ----
// Constants, types and encodings shared by the arithmetic section
// Summary of operation
// - Accesses to external data addresses 0x0800 to 0x08FF are flagged as radio register hits.
// - The accumulator answers at special address 0xE0, the auxiliary register at 0xF0, status at 0xD0.
// - The arithmetic unit is eight bits wide and works with accumulator, auxiliary and status.
// - Status bits from 7 to 0 are carry, half carry, user flag zero, bank select (2), overflow, user flag one, parity.
// - The bank select maps the eight working registers to 0x00, 0x08, 0x10 or 0x18 upward.
// - Add, subtract, multiply, divide, increment, decrement, decimal adjust and compare are supported.
// - AND, OR, exclusive OR, complement and rotate work on byte operands.
// - Single bits can be set, cleared, complemented, tested for jumps, cleared on test, and moved with carry.
// - The auxiliary register feeds and receives multiply and divide, else acts as a plain register.
`default_nettype none
package alu_pkg;
  localparam logic [7:0] ACC_ADDR = 8'hE0;
  localparam logic [7:0] AUX_ADDR = 8'hF0;
  localparam logic [7:0] PSW_ADDR = 8'hD0;
  localparam logic [15:0] RADIO_LO = 16'h0800;
  localparam logic [15:0] RADIO_HI = 16'h08FF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int F0_BIT = 5;
  localparam int RS_HI = 4;
  localparam int RS_LO = 3;
  localparam int OV_BIT = 2;
  localparam int F1_BIT = 1;
  localparam int P_BIT = 0;
  localparam int DIV_STEPS = 8;
  localparam logic [3:0] DIV_LAST = 4'h7;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDC = 5'h02, OP_SUBB = 5'h03,
    OP_INC = 5'h04, OP_DEC = 5'h05, OP_MUL = 5'h06, OP_DIV = 5'h07,
    OP_DA = 5'h08, OP_CMP = 5'h09, OP_AND = 5'h0A, OP_OR = 5'h0B,
    OP_XOR = 5'h0C, OP_CPL = 5'h0D, OP_RL = 5'h0E, OP_RR = 5'h0F,
    OP_RLC = 5'h10, OP_RRC = 5'h11, OP_CLR = 5'h12, OP_BSET = 5'h13,
    OP_BCLR = 5'h14, OP_BCPL = 5'h15, OP_BTST = 5'h16, OP_BTCLR = 5'h17,
    OP_BTOC = 5'h18, OP_CTOB = 5'h19
  } alu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV = 2'b01
  } alu_state_t;
endpackage : alu_pkg
`default_nettype wire

// ---- sfr_if.sv ----
// Special function access channel between core top and status word unit
`default_nettype none
interface sfr_if;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] psw;
  modport core (output wr, output addr, output wdata, input psw);
  modport unit (input wr, input addr, input wdata, output psw);
endinterface : sfr_if
`default_nettype wire

// ---- psw_unit.sv ----
// Program status word register with flag updates and bank mapping
`default_nettype none
module psw_unit (
  input wire logic mclk,
  input wire logic rstn,
  sfr_if.unit sfr,
  input wire logic flag_we,
  input wire logic [7:0] flag_mask,
  input wire logic [7:0] flag_val,
  input wire logic parity,
  output logic [4:0] bank_base
);
  typedef struct packed {
    logic [7:0] psw;
  } psw_state_t;
  psw_state_t st_r, st_nxt;

  // ALU flag update wins over a software write in the same cycle
  always_comb
  begin
    st_nxt = st_r;
    if (sfr.wr && sfr.addr == alu_pkg::PSW_ADDR)
      st_nxt.psw = sfr.wdata;
    if (flag_we)
      st_nxt.psw = (st_nxt.psw & ~flag_mask) | (flag_val & flag_mask);
    st_nxt.psw[alu_pkg::P_BIT] = parity;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Stored parity bit is one cycle behind the accumulator; mux live value
  always_comb
  begin
    sfr.psw = st_r.psw;
    sfr.psw[alu_pkg::P_BIT] = parity;
  end

  // Working registers sit at bank times eight
  assign bank_base = {st_r.psw[alu_pkg::RS_HI:alu_pkg::RS_LO], 3'b000};

  // A plain software write must move the bank base on the next edge
  bank_map_a: assert property (@(posedge mclk) disable iff (!rstn)
    sfr.wr && sfr.addr == alu_pkg::PSW_ADDR && !flag_we |=>
    bank_base == {$past(sfr.wdata[4:3]), 3'b000})
    else $error("bank base mismatch");
  // The stored parity bit trails the live value by exactly one cycle
  parity_live_a: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> st_r.psw[0] == $past(parity))
    else $error("parity flag not tracked");
endmodule : psw_unit
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the eight-bit arithmetic core and its status word
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk;
  logic rstn;
  logic op_valid;
  logic [4:0] op_code;
  logic [7:0] operand;
  logic [2:0] bit_sel;
  logic op_ready;
  logic jump_taken;
  logic bit_out;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [15:0] external_data_space_addr;
  logic radio_sel;
  logic [4:0] bank_base;
  logic jmp;
  logic busy;
  logic [4:0] ops [13];
  logic [7:0] opnds [13];
  logic [7:0] accs [13];
  logic [15:0] xa [4];
  int error_cnt;
  int tests_run;
  int cycles;

  alu_core alu_core_inst (
    .mclk(mclk),
    .rstn(rstn),
    .op_valid(op_valid),
    .op_code(op_code),
    .operand(operand),
    .bit_sel(bit_sel),
    .op_ready(op_ready),
    .jump_taken(jump_taken),
    .bit_out(bit_out),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .external_data_space_addr(external_data_space_addr),
    .radio_sel(radio_sel),
    .bank_base(bank_base)
  );

  // Free-running core clock, 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Strobes last one cycle and are dropped a step after the taking edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
  endtask : sfr_read

  // Holds the request until taken, then waits out a divide with a bound
  task automatic do_op(input logic [4:0] op, input logic [7:0] d, input logic [2:0] bs);
    @(posedge mclk);
    #1;
    op_valid = 1'b1;
    op_code = op;
    operand = d;
    bit_sel = bs;
    for (int i = 0; i < 20 && op_ready !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    jmp = jump_taken;
    busy = ~op_ready;
    for (int i = 0; i < 20 && op_ready !== 1'b1; i++) @(posedge mclk);
  endtask : do_op

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  initial
  begin
    {op_valid, op_code, operand, bit_sel, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    external_data_space_addr = 16'h0000;
    rstn = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    rstn = 1'b1;
    // Reset contents and register placement
    sfr_read(8'hE0, 8'h00, "acc rst");
    sfr_read(8'hF0, 8'h00, "aux rst");
    sfr_read(8'hD0, 8'h00, "psw rst");
    sfr_read(8'h81, 8'h00, "unmapped");
    foreach (xa[i]) xa[i] = 16'h0000;
    xa = '{16'h07FF, 16'h0800, 16'h08FF, 16'h0900};
    foreach (xa[i])
    begin
      external_data_space_addr = xa[i];
      #1;
      chk("radio_sel", {15'h0000, i == 1 || i == 2}, {15'h0000, radio_sel});
    end
    sfr_addr = 8'hF0;
    #1;
    chk("hit aux", 16'h0001, {15'h0000, sfr_hit});
    sfr_addr = 8'hE1;
    #1;
    chk("hit miss", 16'h0000, {15'h0000, sfr_hit});
    // Parity follows the accumulator without any operation
    sfr_write(8'hE0, 8'h07);
    sfr_read(8'hD0, 8'h01, "parity odd");
    sfr_write(8'hE0, 8'h35);
    sfr_read(8'hD0, 8'h00, "parity even");
    sfr_write(8'hF0, 8'h5A);
    sfr_read(8'hF0, 8'h5A, "aux rw");
    sfr_write(8'hD0, 8'hA2);
    sfr_read(8'hD0, 8'hA2, "psw fields");
    for (int b = 0; b < 4; b++)
    begin
      sfr_write(8'hD0, 8'(b << 3));
      chk("bank_base", 16'(b * 8), {11'h000, bank_base});
    end
    sfr_write(8'hD0, 8'h00);
    // Signed overflow and half carry on 0x7F + 1
    sfr_write(8'hE0, 8'h7F);
    do_op(alu_pkg::OP_ADD, 8'h01, 3'h0);
    sfr_read(8'hE0, 8'h80, "add acc");
    sfr_read(8'hD0, 8'h45, "add flags");
    // Chain of byte operations; carry stays clear all along
    ops = '{alu_pkg::OP_AND, alu_pkg::OP_OR, alu_pkg::OP_XOR, alu_pkg::OP_CPL,
      alu_pkg::OP_RL, alu_pkg::OP_RLC, alu_pkg::OP_RRC, alu_pkg::OP_RR, alu_pkg::OP_INC,
      alu_pkg::OP_DEC, alu_pkg::OP_CMP, alu_pkg::OP_SUBB, alu_pkg::OP_CLR};
    opnds = '{8'h3C, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h10, 8'h01, 8'h00};
    accs = '{8'h30, 8'h3F, 8'hC0, 8'h3F, 8'h7E, 8'hFC, 8'h7E, 8'h3F, 8'h40, 8'h3F,
      8'h3F, 8'h3E, 8'h00};
    sfr_write(8'hE0, 8'hF0);
    foreach (ops[i])
    begin
      do_op(ops[i], opnds[i], 3'h0);
      sfr_read(8'hE0, accs[i], "op chain");
    end
    // Multiply and divide through the auxiliary register
    sfr_write(8'hE0, 8'h20);
    sfr_write(8'hF0, 8'h10);
    do_op(alu_pkg::OP_MUL, 8'h00, 3'h0);
    sfr_read(8'hE0, 8'h00, "mul low");
    sfr_read(8'hF0, 8'h02, "mul high");
    sfr_write(8'hE0, 8'h64);
    sfr_write(8'hF0, 8'h07);
    do_op(alu_pkg::OP_DIV, 8'h00, 3'h0);
    chk("div busy", 16'h0001, {15'h0000, busy});
    sfr_read(8'hE0, 8'h0E, "quotient");
    sfr_read(8'hF0, 8'h02, "remainder");
    sfr_write(8'hF0, 8'h00);
    do_op(alu_pkg::OP_DIV, 8'h00, 3'h0);
    sfr_read(8'hE0, 8'h0E, "div zero acc");
    sfr_read(8'hD0, 8'h05, "div zero ov");
    sfr_write(8'hD0, 8'h00);
    sfr_write(8'hE0, 8'h0A);
    do_op(alu_pkg::OP_DA, 8'h00, 3'h0);
    sfr_read(8'hE0, 8'h10, "decimal adj");
    // Single-bit work on the accumulator
    sfr_write(8'hE0, 8'h00);
    do_op(alu_pkg::OP_BSET, 8'h00, 3'h3);
    sfr_read(8'hE0, 8'h08, "bit set");
    do_op(alu_pkg::OP_BTST, 8'h00, 3'h3);
    chk("jump set bit", 16'h0000, {15'h0000, jmp});
    do_op(alu_pkg::OP_BTCLR, 8'h00, 3'h3);
    chk("jump clr", 16'h0001, {15'h0000, jmp});
    do_op(alu_pkg::OP_BTST, 8'h00, 3'h3);
    chk("jump clear bit", 16'h0001, {15'h0000, jmp});
    do_op(alu_pkg::OP_BCPL, 8'h00, 3'h0);
    do_op(alu_pkg::OP_BTOC, 8'h00, 3'h0);
    sfr_read(8'hD0, 8'h81, "bit to carry");
    do_op(alu_pkg::OP_CTOB, 8'h00, 3'h0);
    chk("carry to bit", 16'h0001, {15'h0000, bit_out});
    do_op(alu_pkg::OP_BCLR, 8'h00, 3'h0);
    sfr_read(8'hE0, 8'h00, "bit clear");
    // Carry is still set, so add with carry brings in one extra
    do_op(alu_pkg::OP_ADDC, 8'h01, 3'h0);
    sfr_read(8'hE0, 8'h02, "addc acc");
    sfr_read(8'hD0, 8'h01, "addc flags");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
